// file: rtl/wgt_pkg.sv
// Shared constants for the windowed guard timer.
package wgt_pkg;
    // Width of the down counter and of every compare value.
    localparam int TMR_W = 24;
    // Smallest time-out value, so the shortest period is 256 ticks.
    localparam logic [23:0] TC_MIN = 24'h0000ff;
    // Fixed divide ratio of the prescaler on the guard count clock.
    localparam int PRESCALE_DIV = 4;
    // Feed sequence bytes, first and second.
    localparam logic [7:0] FEED_FIRST = 8'haa;
    localparam logic [7:0] FEED_SECOND = 8'h55;
    // Values after reset.
    localparam logic [23:0] COUNT_RST = 24'hffffff;
    localparam logic FLAG_RST = 1'b0;
    // Feed sequence tracker states.
    typedef enum logic {WGT_FEED_IDLE, WGT_FEED_ARMED} wgt_feed_t;
endpackage

// file: rtl/wgt_prescale.sv
// Guard count clock synchroniser and fixed prescaler.
`timescale 1ns/10ps
module wgt_prescale #(
    parameter int DIV = wgt_pkg::PRESCALE_DIV
) (
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    input wire logic guard_count_clock_in,
    output logic tick_out
);
    // A divider below two would tick on every edge and defeat the point.
    if (DIV < 2) begin : g_chk
        $error("wgt_prescale: DIV must be at least 2");
    end

    localparam int CW = $clog2(DIV);
    logic [2:0] sync;
    logic level;
    logic [CW-1:0] div_cnt;
    logic next_level;
    logic [CW-1:0] next_div_cnt;
    logic next_tick;

    // A level change counts only when stages two and three agree.
    always_comb begin
        next_level = level;
        next_div_cnt = div_cnt;
        next_tick = 1'b0;
        if (sync[1] == sync[2] && sync[2] != level) begin
            next_level = sync[2];
            if (sync[2]) begin
                if (div_cnt == CW'(DIV - 1)) begin
                    next_div_cnt = '0;
                    next_tick = 1'b1;
                end else begin
                    next_div_cnt = div_cnt + CW'(1);
                end
            end
        end
    end

    // The oscillator pin is asynchronous, so it runs through three stages.
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sync <= 3'h0;
            level <= 1'b0;
            div_cnt <= '0;
            tick_out <= 1'b0;
        end else begin
            sync <= {sync[1:0], guard_count_clock_in};
            level <= next_level;
            div_cnt <= next_div_cnt;
            tick_out <= next_tick;
        end
    end
endmodule

// file: rtl/wgt_top.sv
// Windowed guard timer: counter, feed check, window, warning and reset.
//
// Operation
// - Enabled timer asserts chip reset, or interrupt in interrupt mode, when not reloaded before time-out.
// - In window mode a reload is valid only between minimum and maximum.
// - Optional warning interrupt when the counter reaches a programmed value.
// - Software only enables; only reset or a timer event disables.
// - A broken feed sequence raises reset, or interrupt in interrupt mode.
// - A sticky flag tells software a timer reset happened.
// - The counter is 24 bits, programmable, clocked through a prescaler.
// - Period spans 256 to 2^24 counts of four guard clocks.
// - Counting clock comes from the dedicated guard oscillator, not bus.
`timescale 1ns/10ps
module wgt_top (
    input wire logic clk_sys_in,
    input wire logic arst_n_in,
    input wire logic guard_count_clock_in,
    input wire logic enable_set_in,
    input wire logic irq_mode_in,
    input wire logic window_mode_in,
    input wire logic warn_enable_in,
    input wire logic [23:0] timeout_value_in,
    input wire logic [23:0] window_value_in,
    input wire logic [23:0] warn_value_in,
    input wire logic feed_strobe_in,
    input wire logic [7:0] feed_data_in,
    input wire logic irq_clear_in,
    input wire logic warn_clear_in,
    input wire logic reset_flag_clear_in,
    output logic enabled_out,
    output logic [23:0] count_out,
    output logic chip_reset_out,
    output logic guard_irq_out,
    output logic warn_irq_out,
    output logic reset_flag_out
);
    logic rst_meta;
    logic rst_n;
    logic tick;
    wgt_pkg::wgt_feed_t feed_state;
    wgt_pkg::wgt_feed_t next_feed_state;
    logic next_enabled;
    logic [23:0] next_count;
    logic next_chip_reset;
    logic next_guard_irq;
    logic next_warn_irq;
    logic next_reset_flag;
    logic feed_done;
    logic feed_bad;
    logic too_early;
    logic fault;
    logic reload;
    logic expire;
    logic event_hit;

    // Values below the floor are raised so the period never drops under 256.
    function automatic logic [23:0] clamp_tc(input logic [23:0] v);
        clamp_tc = (v < wgt_pkg::TC_MIN) ? wgt_pkg::TC_MIN : v;
    endfunction

    // Reset is released through two stages to avoid a metastable release.
    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    // Ticks come only from the guard oscillator pin, divided by four.
    wgt_prescale #(
        .DIV(wgt_pkg::PRESCALE_DIV)
    ) u_prescale (
        .clk_sys_in(clk_sys_in),
        .rst_n_in(rst_n),
        .guard_count_clock_in(guard_count_clock_in),
        .tick_out(tick)
    );

    // Feed checks; feeds are ignored while the timer is not running.
    always_comb begin
        feed_done = 1'b0;
        feed_bad = 1'b0;
        next_feed_state = feed_state;
        if (!enabled_out || !feed_strobe_in) begin
            next_feed_state = enabled_out ? feed_state
                                          : wgt_pkg::WGT_FEED_IDLE;
        end else begin
            case (feed_state)
                wgt_pkg::WGT_FEED_IDLE: begin
                    if (feed_data_in == wgt_pkg::FEED_FIRST) begin
                        next_feed_state = wgt_pkg::WGT_FEED_ARMED;
                    end else begin
                        feed_bad = 1'b1;
                    end
                end
                wgt_pkg::WGT_FEED_ARMED: begin
                    next_feed_state = wgt_pkg::WGT_FEED_IDLE;
                    if (feed_data_in == wgt_pkg::FEED_SECOND) begin
                        feed_done = 1'b1;
                    end else begin
                        feed_bad = 1'b1;
                    end
                end
                default: begin
                    next_feed_state = wgt_pkg::WGT_FEED_IDLE;
                end
            endcase
        end
    end

    // A feed while the count is still above the window value is too early.
    assign too_early = window_mode_in && (count_out > window_value_in);
    assign fault = feed_bad || (feed_done && too_early);
    assign reload = feed_done && !too_early;
    assign expire = enabled_out && tick && (count_out == 24'h000000) &&
                    !reload;
    assign event_hit = fault || expire;

    // Counter, enable and event outputs.
    always_comb begin
        next_enabled = enabled_out;
        next_count = count_out;
        if (!enabled_out) begin
            if (enable_set_in) begin
                next_enabled = 1'b1;
                next_count = clamp_tc(timeout_value_in);
            end
        end else if (event_hit) begin
            // Software has no path to clear this; only an event does.
            next_enabled = 1'b0;
        end else if (reload) begin
            next_count = clamp_tc(timeout_value_in);
        end else if (tick) begin
            next_count = count_out - 24'h000001;
        end
        next_chip_reset = event_hit && !irq_mode_in;
        // Sticky flags: a new event wins over a clear in the same cycle.
        next_guard_irq = (event_hit && irq_mode_in) ||
                         (guard_irq_out && !irq_clear_in);
        next_warn_irq = (enabled_out && warn_enable_in && tick &&
                         count_out == warn_value_in) ||
                        (warn_irq_out && !warn_clear_in);
        next_reset_flag = next_chip_reset ||
                          (reset_flag_out && !reset_flag_clear_in);
    end

    // All state and outputs except the reset synchroniser register here.
    always_ff @(posedge clk_sys_in or negedge rst_n) begin
        if (!rst_n) begin
            feed_state <= wgt_pkg::WGT_FEED_IDLE;
            enabled_out <= 1'b0;
            count_out <= wgt_pkg::COUNT_RST;
            chip_reset_out <= 1'b0;
            guard_irq_out <= wgt_pkg::FLAG_RST;
            warn_irq_out <= wgt_pkg::FLAG_RST;
            reset_flag_out <= wgt_pkg::FLAG_RST;
        end else begin
            feed_state <= next_feed_state;
            enabled_out <= next_enabled;
            count_out <= next_count;
            chip_reset_out <= next_chip_reset;
            guard_irq_out <= next_guard_irq;
            warn_irq_out <= next_warn_irq;
            reset_flag_out <= next_reset_flag;
        end
    end

    // Checks on the block's own behaviour.
    sequence s_good_feed;
        feed_strobe_in && feed_data_in == wgt_pkg::FEED_FIRST
            && enabled_out && feed_state == wgt_pkg::WGT_FEED_IDLE
            && !tick ##1 feed_strobe_in
            && feed_data_in == wgt_pkg::FEED_SECOND && !too_early;
    endsequence

    property p_expire_reset;
        @(posedge clk_sys_in) disable iff (!rst_n)
        (enabled_out && tick && count_out == 24'h000000 && !irq_mode_in
         && !feed_strobe_in) |=> chip_reset_out && !enabled_out;
    endproperty
    a_expire_reset: assert property (p_expire_reset)
        else $error("time-out did not reset the chip");

    property p_early_feed;
        @(posedge clk_sys_in) disable iff (!rst_n)
        (feed_done && window_mode_in && count_out > window_value_in)
            |=> !enabled_out && (chip_reset_out || guard_irq_out);
    endproperty
    a_early_feed: assert property (p_early_feed)
        else $error("early feed was not treated as a fault");

    property p_warn;
        @(posedge clk_sys_in) disable iff (!rst_n)
        (enabled_out && warn_enable_in && tick && count_out == warn_value_in)
            |=> warn_irq_out;
    endproperty
    a_warn: assert property (p_warn)
        else $error("warning interrupt missing");

    property p_no_sw_disable;
        @(posedge clk_sys_in) disable iff (!rst_n)
        $fell(enabled_out) |-> $past(event_hit);
    endproperty
    a_no_sw_disable: assert property (p_no_sw_disable)
        else $error("enable dropped without a timer event");

    property p_bad_feed;
        @(posedge clk_sys_in) disable iff (!rst_n)
        (enabled_out && feed_strobe_in && feed_state == wgt_pkg::WGT_FEED_IDLE
         && feed_data_in != wgt_pkg::FEED_FIRST)
            |=> (irq_mode_in ? guard_irq_out : chip_reset_out)[*1]
                ##1 !chip_reset_out;
    endproperty
    a_bad_feed: assert property (p_bad_feed)
        else $error("bad feed byte did not raise a fault");

    // The flag must come with the pulse and still be set one cycle later unless cleared.
    property p_flag;
        @(posedge clk_sys_in) disable iff (!rst_n)
        chip_reset_out |-> reset_flag_out
            ##1 (reset_flag_out || $past(reset_flag_clear_in));
    endproperty
    a_flag: assert property (p_flag)
        else $error("reset flag not set with chip reset");

    property p_count_down;
        @(posedge clk_sys_in) disable iff (!rst_n)
        (enabled_out && tick && count_out != 24'h000000 && !feed_strobe_in)
            |=> count_out == $past(count_out) - 24'h000001;
    endproperty
    a_count_down: assert property (p_count_down)
        else $error("counter did not step down on a tick");

    property p_reload;
        @(posedge clk_sys_in) disable iff (!rst_n)
        s_good_feed |=> count_out == clamp_tc($past(timeout_value_in))
            && enabled_out;
    endproperty
    a_reload: assert property (p_reload)
        else $error("valid feed did not reload the counter");

    property p_hold;
        @(posedge clk_sys_in) disable iff (!rst_n)
        (enabled_out && !tick && !feed_strobe_in) |=> $stable(count_out);
    endproperty
    a_hold: assert property (p_hold)
        else $error("counter moved without a guard clock tick");
endmodule

// file: testbench/wgt_top_test.sv
// Self-checking bench for the windowed guard timer top level.
`timescale 1ns/10ps
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin fail_count++; \
    $display("[ERR] t=%0t got=%h exp=%h", $time, a, e); end end
module wgt_top_test;
    logic clk_sys_in = 1'b0;
    logic arst_n_in = 1'b0;
    logic guard_count_clock_in = 1'b0;
    logic enable_set_in = 1'b0;
    logic irq_mode_in = 1'b0;
    logic window_mode_in = 1'b0;
    logic warn_enable_in = 1'b0;
    logic [23:0] timeout_value_in = 24'h000000;
    logic [23:0] window_value_in = 24'h000000;
    logic [23:0] warn_value_in = 24'h000000;
    logic feed_strobe_in = 1'b0;
    logic [7:0] feed_data_in = 8'h00;
    logic irq_clear_in = 1'b0;
    logic warn_clear_in = 1'b0;
    logic reset_flag_clear_in = 1'b0;
    logic enabled_out;
    logic [23:0] count_out;
    logic chip_reset_out;
    logic guard_irq_out;
    logic warn_irq_out;
    logic reset_flag_out;
    int fail_count = 0;
    int check_count = 0;
    int reset_pulses = 0;

    wgt_top u_wgt_top (.clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in),
        .guard_count_clock_in(guard_count_clock_in),
        .enable_set_in(enable_set_in), .irq_mode_in(irq_mode_in),
        .window_mode_in(window_mode_in), .warn_enable_in(warn_enable_in),
        .timeout_value_in(timeout_value_in),
        .window_value_in(window_value_in), .warn_value_in(warn_value_in),
        .feed_strobe_in(feed_strobe_in), .feed_data_in(feed_data_in),
        .irq_clear_in(irq_clear_in), .warn_clear_in(warn_clear_in),
        .reset_flag_clear_in(reset_flag_clear_in),
        .enabled_out(enabled_out), .count_out(count_out),
        .chip_reset_out(chip_reset_out), .guard_irq_out(guard_irq_out),
        .warn_irq_out(warn_irq_out), .reset_flag_out(reset_flag_out));

    // System clock, 8 ns period.
    always #4 clk_sys_in = ~clk_sys_in;

    // Counts cycles with the chip reset high, so a stretched pulse shows.
    // Sampled mid-cycle so the registered pulse has settled.
    always @(negedge clk_sys_in) begin
        if (chip_reset_out === 1'b1) reset_pulses++;
    end

    // Guard clock groups of four edges keep the prescaler phase known.
    task automatic guard_edges(input int n);
        repeat (n) begin
            guard_count_clock_in = 1'b1;
            repeat (4) @(negedge clk_sys_in);
            guard_count_clock_in = 1'b0;
            repeat (4) @(negedge clk_sys_in);
        end
        repeat (8) @(negedge clk_sys_in);
    endtask

    // One feed byte, a single strobe cycle.
    task automatic feed(input logic [7:0] b);
        @(negedge clk_sys_in);
        feed_strobe_in = 1'b1;
        feed_data_in = b;
        @(negedge clk_sys_in);
        feed_strobe_in = 1'b0;
        repeat (2) @(negedge clk_sys_in);
    endtask

    // Both feed bytes on back-to-back cycles, the tightest legal spacing.
    task automatic feed_pair();
        @(negedge clk_sys_in);
        feed_strobe_in = 1'b1;
        feed_data_in = 8'haa;
        @(negedge clk_sys_in);
        feed_data_in = 8'h55;
        @(negedge clk_sys_in);
        feed_strobe_in = 1'b0;
        repeat (2) @(negedge clk_sys_in);
    endtask

    // Start request with a reload value.
    task automatic start(input logic [23:0] tc);
        @(negedge clk_sys_in);
        enable_set_in = 1'b1;
        timeout_value_in = tc;
        @(negedge clk_sys_in);
        enable_set_in = 1'b0;
        @(negedge clk_sys_in);
    endtask

    // Pulses one of the clear inputs for a cycle.
    task automatic pulse(ref logic s);
        @(negedge clk_sys_in);
        s = 1'b1;
        @(negedge clk_sys_in);
        s = 1'b0;
        @(negedge clk_sys_in);
    endtask

    task automatic report_and_stop();
        $display("checks=%0d mismatches=%0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Cuts a hang short; the full run needs roughly 70 us.
    initial begin
        #400000;
        fail_count++;
        report_and_stop();
    end

    initial begin
        repeat (6) @(negedge clk_sys_in);
        arst_n_in = 1'b1;
        repeat (3) @(negedge clk_sys_in);
        `CHK(count_out, 24'hffffff)
        feed(8'h12);
        `CHK(enabled_out, 1'b0)
        `CHK(reset_pulses, 0)
        $display("test idle done");
        start(24'h000010);
        `CHK(count_out, 24'h0000ff)
        start(24'h000500);
        repeat (100) @(negedge clk_sys_in);
        `CHK(count_out, 24'h0000ff)
        `CHK(enabled_out, 1'b1)
        // The ignored start left a new reload value; put the floor back.
        timeout_value_in = 24'h0000ff;
        $display("test start done");
        warn_enable_in = 1'b1;
        warn_value_in = 24'h0000fe;
        guard_edges(8);
        `CHK(count_out, 24'h0000fd)
        `CHK(warn_irq_out, 1'b1)
        warn_enable_in = 1'b0;
        pulse(warn_clear_in);
        `CHK(warn_irq_out, 1'b0)
        feed(8'haa);
        feed(8'h55);
        `CHK(count_out, 24'h0000ff)
        $display("test warn and feed done");
        guard_edges(1020);
        `CHK(enabled_out, 1'b1)
        `CHK(warn_irq_out, 1'b0)
        guard_edges(4);
        `CHK(reset_pulses, 1)
        `CHK(enabled_out, 1'b0)
        `CHK(reset_flag_out, 1'b1)
        pulse(reset_flag_clear_in);
        `CHK(reset_flag_out, 1'b0)
        $display("test timeout done");
        start(24'h0001ff);
        feed(8'haa);
        feed(8'h12);
        `CHK(reset_pulses, 2)
        `CHK(reset_flag_out, 1'b1)
        `CHK(enabled_out, 1'b0)
        pulse(reset_flag_clear_in);
        $display("test bad feed done");
        irq_mode_in = 1'b1;
        window_mode_in = 1'b1;
        window_value_in = 24'h0001fb;
        start(24'h0001ff);
        feed(8'h55);
        `CHK(guard_irq_out, 1'b1)
        `CHK(enabled_out, 1'b0)
        `CHK(reset_flag_out, 1'b0)
        pulse(irq_clear_in);
        start(24'h0001ff);
        feed(8'haa);
        feed(8'h55);
        `CHK(guard_irq_out, 1'b1)
        `CHK(enabled_out, 1'b0)
        `CHK(reset_pulses, 2)
        `CHK(reset_flag_out, 1'b0)
        pulse(irq_clear_in);
        `CHK(guard_irq_out, 1'b0)
        start(24'h0001ff);
        guard_edges(16);
        `CHK(count_out, 24'h0001fb)
        feed_pair();
        `CHK(count_out, 24'h0001ff)
        `CHK(enabled_out, 1'b1)
        `CHK(guard_irq_out, 1'b0)
        $display("test window done");
        report_and_stop();
    end
endmodule
